// *** hdl/cwrc_master_clear_pin_filter.sv ***
// Purpose: glitch filter for the active-low master clear pin
// Assumes: pin sampled synchronously to clk_i
// Notes:   level changes only after FILT_CYC equal samples in a row
`timescale 1ns/1ps
module cwrc_master_clear_pin_filter
  import cwrc_pkg::*;
#(
  parameter int FILT_CYC = MASTER_CLEAR_PIN_FILT_CYC
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_n_i,
  output logic      level_n_o,
  output logic      fall_o
);

  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

  logic [CW-1:0] count;

  // a pulse shorter than FILT_CYC samples restarts the count and is dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count     <= '0;
      level_n_o <= 1'b1;
      fall_o    <= 1'b0;
    end
    else
    begin
      fall_o <= 1'b0;
      if (pin_n_i == level_n_o)
        count <= '0;
      else if (count == LAST)
      begin
        count     <= '0;
        level_n_o <= pin_n_i;
        fall_o    <= ~pin_n_i;
      end
      else
        count <= count + CW'(1);
    end
  end

endmodule : cwrc_master_clear_pin_filter

// *** hdl/cwrc_pkg.sv ***
// Purpose: shared constants for the configuration word and reset control
// Assumes: 10 MHz system clock, 32-bit classic Wishbone register port
// Notes:   one word per register, byte addresses below
package cwrc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // configuration word layout
  localparam int          CFG_W          = 14;
  localparam int          CFG_CP_BIT     = 13;
  localparam int          CFG_BROWNOUT_THRESHOLD_SELECT_BIT   = 7;
  localparam int          CFG_BROWNOUT_ENABLE_BIT  = 6;
  localparam int          CFG_POWERUP_TIMER_ENABLE_N_BIT  = 3;
  localparam int          CFG_WATCHDOG_ENABLE_BIT   = 2;
  localparam int          CFG_OSC_HI     = 1;
  localparam int          CFG_OSC_LO     = 0;
  localparam logic [13:0] CFG_UNIMPL     = 14'h1f30;
  localparam logic [13:0] CFG_ERASED     = 14'h3fff;

  localparam logic [1:0]  OSC_RC         = 2'h3;
  localparam logic [1:0]  OSC_HS         = 2'h2;
  localparam logic [1:0]  OSC_XT         = 2'h1;
  localparam logic [1:0]  OSC_LP         = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int          ADR_W          = 8;
  localparam logic [7:0]  REG_CONFIG     = 8'h00;
  localparam logic [7:0]  REG_FLAGS      = 8'h04;
  localparam logic [7:0]  REG_CAUSE      = 8'h08;
  localparam logic [7:0]  REG_IRQ_STAT   = 8'h0c;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h10;

  localparam int          FLAG_TO_BIT    = 0;
  localparam int          FLAG_PD_BIT    = 1;
  localparam int          FLAG_SLEEP_BIT = 2;

  // reset cause bit positions, shared by cause, status and mask registers
  localparam int          CAUSE_W        = 6;
  localparam int          C_POR          = 0;
  localparam int          C_MASTER_CLEAR_PIN_RUN     = 1;
  localparam int          C_MASTER_CLEAR_PIN_SLEEP   = 2;
  localparam int          C_WDT_RUN      = 3;
  localparam int          C_WDT_WAKE     = 4;
  localparam int          C_BOR          = 5;
  localparam logic [5:0]  CAUSE_RESET    = 6'h01;
  localparam logic [5:0]  MASK_RESET     = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          MASTER_CLEAR_PIN_FILT_NS   = 2000;
  localparam int          MASTER_CLEAR_PIN_FILT_CYC  =
    (MASTER_CLEAR_PIN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_HOLD  = 3'b100
  } cwrc_state_t;

endpackage : cwrc_pkg

// *** hdl/cwrc_reset_ctrl.sv ***
// Purpose: configuration word decode and reset source classification
// Assumes: all inputs synchronous to clk_i; Wishbone classic slave
// Notes:   reset class outputs steer the core; flags tell software why
`timescale 1ns/1ps
module cwrc_reset_ctrl
  import cwrc_pkg::*;
#(
  parameter logic [13:0] CFG_INIT = CFG_ERASED,
  parameter int          FILT_CYC = MASTER_CLEAR_PIN_FILT_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // reset sources and core events
  input  wire logic        program_mode_i,
  input  wire logic        supply_good_i,
  input  wire logic        master_clear_pin_n_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic        brownout_detect_i,
  input  wire logic        sleep_i,
  input  wire logic        clrwdt_i,
  input  wire logic        wake_irq_i,
  // master clear pin drive, never used
  output logic             master_clear_pin_o,
  output logic             master_clear_pin_oe_o,
  // decoded configuration
  output logic             code_protect_o,
  output logic             brownout_threshold_select_o,
  output logic             brownout_enable_o,
  output logic             powerup_timer_en_o,
  output logic             watchdog_enable_o,
  output logic      [3:0]  osc_mode_o,
  output logic             ext_clock_ok_o,
  // reset class outputs
  output logic             core_reset_o,
  output logic             por_pulse_o,
  output logic             wake_resume_o,
  output logic             sleeping_o,
  output logic             timeout_flag_o,
  output logic             powerdown_flag_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : merge_bytes

  function automatic logic [31:0] w1c(input logic [31:0] v,
                                      input logic [3:0]  sel);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = v[i*8 +: 8];
    return r;
  endfunction : w1c

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [13:0]     cfg_word;
  logic [13:0]     cfg_view;
  logic [5:0]      cause;
  logic [5:0]      irq_stat;
  logic [5:0]      irq_mask;
  logic [5:0]      next_cause_evt;
  logic            timeout_flag;
  logic            powerdown_flag;
  cwrc_state_t     state;
  cwrc_state_t     next_state;
  logic            por_pend;
  logic            supply_q;
  logic            bor_q;
  logic            master_clear_pin_level_n;
  logic            master_clear_pin_fall;
  logic            por_evt;
  logic            bor_evt;
  logic            wdt_evt;
  logic            hold_src;
  logic            bus_req;
  logic            bus_wr;
  logic [31:0]     rd_word;
  logic [31:0]     wr_cfg;
  logic [5:0]      clr_bits;

  ////////////////////////////////////////////////////////////////////////////
  // configuration word decode

  // stored bits below are ignored where unimplemented, reads force them high
  assign cfg_view = cfg_word | CFG_UNIMPL;

  assign code_protect_o              = ~cfg_word[CFG_CP_BIT];
  assign brownout_threshold_select_o = cfg_word[CFG_BROWNOUT_THRESHOLD_SELECT_BIT];
  assign brownout_enable_o           = cfg_word[CFG_BROWNOUT_ENABLE_BIT];
  // power-up delay depends on its own bit only, never on brown-out enable
  assign powerup_timer_en_o          = ~cfg_word[CFG_POWERUP_TIMER_ENABLE_N_BIT];
  assign watchdog_enable_o           = cfg_word[CFG_WATCHDOG_ENABLE_BIT];

  always_comb
  begin
    unique case (cfg_word[CFG_OSC_HI:CFG_OSC_LO])
      OSC_RC:  osc_mode_o = 4'h8;
      OSC_HS:  osc_mode_o = 4'h4;
      OSC_XT:  osc_mode_o = 4'h2;
      OSC_LP:  osc_mode_o = 4'h1;
    endcase
  end

  // the crystal modes take a driven clock as readily as a crystal
  assign ext_clock_ok_o = (cfg_word[CFG_OSC_HI:CFG_OSC_LO] != OSC_RC);

  // the watchdog acts inside the core only, the pin is never driven
  assign master_clear_pin_o    = 1'b0;
  assign master_clear_pin_oe_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // reset source detection

  cwrc_master_clear_pin_filter #(
    .FILT_CYC  (FILT_CYC)
  ) u_master_clear_pin_filter (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .pin_n_i   (master_clear_pin_n_i),
    .level_n_o (master_clear_pin_level_n),
    .fall_o    (master_clear_pin_fall)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      por_pend <= 1'b1;
      supply_q <= 1'b0;
      bor_q    <= 1'b0;
    end
    else
    begin
      por_pend <= 1'b0;
      supply_q <= supply_good_i;
      bor_q    <= brownout_enable_o & brownout_detect_i;
    end
  end

  // a rising supply, or leaving the system reset, counts as power-on
  assign por_evt = por_pend | (supply_good_i & ~supply_q);
  assign bor_evt = brownout_enable_o & brownout_detect_i & ~bor_q;
  assign wdt_evt = watchdog_enable_o & wdt_timeout_i;

  // levels that keep the core in reset for as long as they last
  assign hold_src = ~supply_good_i | ~master_clear_pin_level_n
                  | (brownout_enable_o & brownout_detect_i);

  ////////////////////////////////////////////////////////////////////////////
  // cause classification, highest priority first

  always_comb
  begin
    next_cause_evt = '0;
    if (por_evt)
      next_cause_evt[C_POR] = 1'b1;
    else if (bor_evt)
      next_cause_evt[C_BOR] = 1'b1;
    else if (master_clear_pin_fall && state == ST_SLEEP)
      next_cause_evt[C_MASTER_CLEAR_PIN_SLEEP] = 1'b1;
    else if (master_clear_pin_fall)
      next_cause_evt[C_MASTER_CLEAR_PIN_RUN] = 1'b1;
    else if (wdt_evt && state == ST_SLEEP)
      next_cause_evt[C_WDT_WAKE] = 1'b1;
    else if (wdt_evt && state == ST_RUN)
      next_cause_evt[C_WDT_RUN] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating state

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_RUN:
        if (hold_src || por_evt)
          next_state = ST_HOLD;
        else if (sleep_i)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (hold_src || por_evt)
          next_state = ST_HOLD;
        else if (wdt_evt || wake_irq_i)
          next_state = ST_RUN;
      ST_HOLD:
        if (!hold_src && !por_evt)
          next_state = ST_RUN;
      default:
        next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ST_HOLD;
    else
      state <= next_state;
  end

  assign sleeping_o = (state == ST_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // reset class outputs

  // core_reset loads reset state; the unaffected class is not wired to it,
  // so those registers keep their value and only power-on leaves them open
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_reset_o  <= 1'b1;
      por_pulse_o   <= 1'b0;
      wake_resume_o <= 1'b0;
    end
    else
    begin
      core_reset_o  <= hold_src | por_evt | next_cause_evt[C_WDT_RUN];
      por_pulse_o   <= next_cause_evt[C_POR];
      // watchdog wake resumes execution without touching core state
      wake_resume_o <= next_cause_evt[C_WDT_WAKE]
                     | (sleeping_o & wake_irq_i & ~hold_src & ~por_evt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout and powerdown flags

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end
    else if (next_cause_evt[C_POR] || next_cause_evt[C_BOR])
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end
    else if (next_cause_evt[C_MASTER_CLEAR_PIN_SLEEP])
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end
    else if (next_cause_evt[C_WDT_WAKE])
    begin
      timeout_flag   <= 1'b0;
      powerdown_flag <= 1'b0;
    end
    else if (next_cause_evt[C_WDT_RUN])
    begin
      timeout_flag   <= 1'b0;
      powerdown_flag <= 1'b1;
    end
    else if (sleeping_o && wake_irq_i && !hold_src)
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end
    else if (state == ST_RUN && sleep_i)
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end
    else if (state == ST_RUN && clrwdt_i)
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end
    // master clear while running leaves both flags as they were
  end

  assign timeout_flag_o   = timeout_flag;
  assign powerdown_flag_o = powerdown_flag;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign bus_wr  = bus_req & we_i;
  assign wr_cfg  = merge_bytes({18'h0, cfg_word}, dat_i, sel_i);
  assign clr_bits = (bus_wr && adr_i == REG_IRQ_STAT)
                  ? 6'(w1c(dat_i, sel_i)) : 6'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= bus_req;
  end

  // the word is only reachable in programming mode; writes store 0 for
  // programmed and 1 for erased bits as given, with the unimplemented bits stored as 1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_word <= CFG_INIT;
    else if (bus_wr && adr_i == REG_CONFIG && program_mode_i)
      cfg_word <= wr_cfg[13:0] | CFG_UNIMPL;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask <= MASK_RESET;
    else if (bus_wr && adr_i == REG_IRQ_MASK && sel_i[0])
      irq_mask <= dat_i[5:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cause <= CAUSE_RESET;
    else if (next_cause_evt != 6'h0)
      cause <= next_cause_evt;
  end

  // a new event in the clearing cycle stays set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat <= 6'h0;
    else
      irq_stat <= (irq_stat & ~clr_bits) | next_cause_evt;
  end

  assign irq_o = |(irq_stat & irq_mask);

  always_comb
  begin
    rd_word = 32'h0;
    unique case (adr_i)
      REG_CONFIG:
        if (program_mode_i)
          rd_word = {18'h0, cfg_view};
      REG_FLAGS:
      begin
        rd_word[FLAG_TO_BIT]    = timeout_flag;
        rd_word[FLAG_PD_BIT]    = powerdown_flag;
        rd_word[FLAG_SLEEP_BIT] = sleeping_o;
      end
      REG_CAUSE:    rd_word = {26'h0, cause};
      REG_IRQ_STAT: rd_word = {26'h0, irq_stat};
      REG_IRQ_MASK: rd_word = {26'h0, irq_mask};
      default:      rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (bus_req && !we_i)
      dat_o <= rd_word;
    else
      dat_o <= 32'h0;
  end

endmodule : cwrc_reset_ctrl

// *** sim/cwrc_pin_partner.sv ***
// Purpose: far-side model of the master clear pin driver
// Assumes: pin has a pull-up; drive changes just after a clock edge
// Notes:   press() holds the pin low for n clock samples
`timescale 1ns/1ps
module cwrc_pin_partner
(
  input  wire logic clk_i,
  output logic      pin_n_o
);
  ////////////////////////////////////////////////////////////////
  // idle level is the pull-up, so no external reset parts needed
  initial pin_n_o = 1'b1;

  task automatic press(input int n);
    @(posedge clk_i);
    pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    pin_n_o <= 1'b1;
  endtask : press
endmodule : cwrc_pin_partner

// *** sim/cwrc_reset_ctrl_asserts.sv ***
// Purpose: port-level checks on the reset controller
// Assumes: single clock domain, rst_i synchronous active high
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module cwrc_reset_ctrl_asserts
  import cwrc_pkg::*;
#(
  parameter int FILT_CYC = MASTER_CLEAR_PIN_FILT_CYC
)
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       supply_good_i,
  input wire logic       master_clear_pin_n_i,
  input wire logic       wdt_timeout_i,
  input wire logic       brownout_detect_i,
  input wire logic       master_clear_pin_o,
  input wire logic       master_clear_pin_oe_o,
  input wire logic       watchdog_enable_o,
  input wire logic [3:0] osc_mode_o,
  input wire logic       ext_clock_ok_o,
  input wire logic       core_reset_o,
  input wire logic       por_pulse_o,
  input wire logic       wake_resume_o,
  input wire logic       sleeping_o,
  input wire logic       timeout_flag_o,
  input wire logic       powerdown_flag_o
);
  logic [7:0] low_run;
  logic       quiet;

  // consecutive low samples of the pin, saturating
  always_ff @(posedge clk_i)
  begin
    if (rst_i || master_clear_pin_n_i)
      low_run <= 8'h00;
    else if (low_run != 8'hff)
      low_run <= low_run + 8'h01;
  end

  assign quiet = supply_good_i && !brownout_detect_i && master_clear_pin_n_i;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_pin_undriven: assert property (!master_clear_pin_oe_o && !master_clear_pin_o)
    else $error("master clear pin driven");
  chk_osc_decode: assert property ($onehot(osc_mode_o) && ext_clock_ok_o == !osc_mode_o[3])
    else $error("oscillator decode wrong");
  chk_glitch_ignored: assert property ($rose(master_clear_pin_n_i) && low_run < FILT_CYC && !core_reset_o && quiet && !wdt_timeout_i |-> !core_reset_o [*3])
    else $error("short pin pulse caused reset");
  chk_long_clear: assert property (low_run == FILT_CYC + 3 |-> core_reset_o)
    else $error("held pin gave no reset");
  chk_sleep_flags: assert property ($rose(sleeping_o) |-> timeout_flag_o && !powerdown_flag_o)
    else $error("flags wrong on sleep");
  chk_wdt_wake: assert property (sleeping_o && wdt_timeout_i && watchdog_enable_o && quiet |=> !sleeping_o && wake_resume_o && !timeout_flag_o && !powerdown_flag_o && !core_reset_o)
    else $error("watchdog wake wrong");
  chk_wdt_reset: assert property (!sleeping_o && !core_reset_o && wdt_timeout_i && watchdog_enable_o && quiet |-> ##[1:3] core_reset_o)
    else $error("watchdog reset missing");
  chk_wdt_off: assert property (!sleeping_o && !core_reset_o && wdt_timeout_i && !watchdog_enable_o && quiet |=> !core_reset_o [*3])
    else $error("disabled watchdog acted");
  chk_por_pulse: assert property ($rose(supply_good_i) |-> ##[1:4] por_pulse_o)
    else $error("no power-on pulse");
endmodule : cwrc_reset_ctrl_asserts

// *** sim/cwrc_reset_ctrl_tb_top.sv ***
// Purpose: self-checking bench for the reset controller
// Assumes: pin filter shortened to 3 cycles
// Notes:   registers reached through classic Wishbone tasks
`timescale 1ns/1ps
module cwrc_reset_ctrl_tb_top
  import cwrc_pkg::*;
;
  localparam int FC = 3;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        we_i = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        ack_o;
  logic        program_mode_i = 1'b0;
  logic        supply_good_i = 1'b1;
  logic        master_clear_pin_n_i;
  logic        wdt_timeout_i = 1'b0;
  logic        brownout_detect_i = 1'b0;
  logic        sleep_i = 1'b0;
  logic        clrwdt_i = 1'b0;
  logic        wake_irq_i = 1'b0;
  logic        master_clear_pin_o, master_clear_pin_oe_o, code_protect_o;
  logic        brownout_threshold_select_o, brownout_enable_o;
  logic        powerup_timer_en_o, watchdog_enable_o, ext_clock_ok_o;
  logic [3:0]  osc_mode_o;
  logic        core_reset_o, por_pulse_o, wake_resume_o, sleeping_o;
  logic        timeout_flag_o, powerdown_flag_o, irq_o;
  logic [31:0] q;
  logic [13:0] c;
  logic [13:0] cfg_tab [4] = '{14'h0000, 14'h2049, 14'h0046, 14'h3fff};
  int          n_mismatch = 0;
  int          tests_run = 0;

  cwrc_reset_ctrl #(.CFG_INIT(CFG_ERASED), .FILT_CYC(FC)) dut_u (.*);
  cwrc_pin_partner pin_u (.clk_i(clk_i), .pin_n_o(master_clear_pin_n_i));

  always #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    if (ack_o !== 1'b1)
      n_mismatch++;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rd

  task automatic pulse(input logic [4:0] m);
    @(posedge clk_i);
    {brownout_detect_i, wake_irq_i, clrwdt_i, wdt_timeout_i, sleep_i} <= m;
    @(posedge clk_i);
    {brownout_detect_i, wake_irq_i, clrwdt_i, wdt_timeout_i, sleep_i} <= 5'h0;
    repeat (3) @(posedge clk_i);
  endtask : pulse

  // mask rewritten first: a reset may have returned it to zero
  task automatic ev(input int b, input logic [31:0] f);
    wb(REG_IRQ_MASK, 1'b1, 32'h3f);
    rd(REG_CAUSE, 32'h1 << b);
    rd(REG_FLAGS, f);
    chk({31'h0, irq_o}, 32'h1);
    wb(REG_IRQ_STAT, 1'b1, 32'h1 << b);
    rd(REG_IRQ_STAT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
  endtask : ev

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(REG_CAUSE, 32'h1 << C_POR);
    rd(REG_FLAGS, 32'h3);
    rd(REG_IRQ_MASK, 32'h0);
    rd(REG_IRQ_STAT, 32'h1);
    chk({31'h0, irq_o | core_reset_o}, 32'h0);
    $display("test reset done");
    wb(REG_CONFIG, 1'b1, 32'h0);
    rd(REG_CONFIG, 32'h0);
    wb(8'h14, 1'b1, 32'hffffffff);
    rd(8'h14, 32'h0);
    program_mode_i <= 1'b1;
    rd(REG_CONFIG, 32'h3fff);
    foreach (cfg_tab[i])
    begin
      c = cfg_tab[i];
      wb(REG_CONFIG, 1'b1, {18'h0, c});
      rd(REG_CONFIG, {18'h0, c | CFG_UNIMPL});
      chk({23'h0, code_protect_o, brownout_threshold_select_o,
           brownout_enable_o, powerup_timer_en_o, watchdog_enable_o,
           osc_mode_o}, {23'h0, ~c[13], c[7], c[6], ~c[3], c[2],
           4'h1 << c[1:0]});
    end
    program_mode_i <= 1'b0;
    $display("test config done");
    ev(C_POR, 32'h3);
    pin_u.press(FC - 1);
    repeat (3) @(posedge clk_i);
    chk({31'h0, core_reset_o}, 32'h0);
    rd(REG_IRQ_STAT, 32'h0);
    pin_u.press(FC + 4);
    repeat (3) @(posedge clk_i);
    ev(C_MASTER_CLEAR_PIN_RUN, 32'h3);
    $display("test master clear done");
    pulse(5'h01);
    rd(REG_FLAGS, 32'h5);
    pulse(5'h02);
    ev(C_WDT_WAKE, 32'h0);
    pulse(5'h02);
    ev(C_WDT_RUN, 32'h2);
    pulse(5'h04);
    rd(REG_FLAGS, 32'h3);
    $display("test watchdog done");
    program_mode_i <= 1'b1;
    wb(REG_CONFIG, 1'b1, 32'h3fbb);
    program_mode_i <= 1'b0;
    pulse(5'h12);
    rd(REG_IRQ_STAT, 32'h0);
    rd(REG_FLAGS, 32'h3);
    program_mode_i <= 1'b1;
    wb(REG_CONFIG, 1'b1, 32'h3fff);
    program_mode_i <= 1'b0;
    $display("test disabled sources done");
    pulse(5'h01);
    pin_u.press(FC + 4);
    repeat (3) @(posedge clk_i);
    ev(C_MASTER_CLEAR_PIN_SLEEP, 32'h1);
    pulse(5'h01);
    pulse(5'h08);
    rd(REG_FLAGS, 32'h1);
    pulse(5'h10);
    ev(C_BOR, 32'h3);
    supply_good_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, core_reset_o}, 32'h1);
    supply_good_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ev(C_POR, 32'h3);
    $display("test sleep and supply done");
    close_out();
  end
endmodule : cwrc_reset_ctrl_tb_top

bind cwrc_reset_ctrl cwrc_reset_ctrl_asserts #(.FILT_CYC(FILT_CYC)) chk_u (.*);
